// file: rtl/iopc_pin_drv.sv
/*
 One output stage: push-pull or open drain, from a logical level.
 Assumes the wire level is resolved outside from o and oe.
*/
`timescale 1ns/1ps
module iopc_pin_drv
(
   input wire logic level,           // Wanted pin level
   input wire logic open_drain,      // Open drain when high
   input wire logic active,          // Pin owned as output
   output iopc_pkg::iopc_pin_drv_s drv  // Output and enable
);
   import iopc_pkg::*;
   // Open drain only pulls low; high is released to the pull-up
   always_comb
   begin
      drv.o = level;
      drv.oe = active & (~open_drain | ~level);
      if (open_drain)
      begin
         drv.o = 1'b0;
      end
   end
endmodule // iopc_pin_drv

// file: rtl/iopc_pkg.sv
/*
 Package for the pin configuration and clock output block: field layouts,
 reset values, mode encodings and timing counts.
 Assumes a single 200 MHz system clock domain.
*/
package iopc_pkg;
   // Reference choices accepted by the oscillator
   localparam logic [1:0] IOPC_REF_40M = 2'h0;
   localparam logic [1:0] IOPC_REF_20M = 2'h1;
   localparam logic [1:0] IOPC_REF_4M = 2'h2;
   // Reference frequencies in MHz
   localparam int IOPC_REF_40_MHZ = 40;
   localparam int IOPC_REF_20_MHZ = 20;
   localparam int IOPC_REF_4_MHZ = 4;
   localparam int IOPC_PLL_MULT = 10;
   localparam int IOPC_SYS_DIV = 2;
   // Clock output divider select encodings
   localparam logic [1:0] IOPC_CDIV_1 = 2'h0;
   localparam logic [1:0] IOPC_CDIV_2 = 2'h1;
   localparam logic [1:0] IOPC_CDIV_4 = 2'h2;
   localparam logic [1:0] IOPC_CDIV_10 = 2'h3;
   localparam logic [3:0] IOPC_CDIV_HALF_1 = 4'h0;
   localparam logic [3:0] IOPC_CDIV_HALF_2 = 4'h1;
   localparam logic [3:0] IOPC_CDIV_HALF_4 = 4'h3;
   localparam logic [3:0] IOPC_CDIV_HALF_10 = 4'h9;
   // Start of frame timing, in oscillator periods of the generated clock
   localparam int IOPC_SOF_DELAY_TOSC = 1;
   localparam int IOPC_SOF_HIGH_TOSC = 31;
   localparam logic [4:0] IOPC_SOF_HIGH_CNT = 5'(IOPC_SOF_HIGH_TOSC);
   localparam logic [4:0] IOPC_SOF_DELAY_CNT = 5'(IOPC_SOF_DELAY_TOSC);
   // Pin configuration bit positions
   localparam int IOPC_CFG_SOF_SEL = 0;
   localparam int IOPC_CFG_TX_OD = 1;
   localparam int IOPC_CFG_IRQ_OD = 2;
   localparam int IOPC_CFG_PIN0_IRQ = 3;
   localparam int IOPC_CFG_PIN1_IRQ = 4;
   localparam int IOPC_CFG_STBY_EN = 5;
   localparam logic [5:0] IOPC_CFG_RST = 6'h00;
   // Oscillator control reset values
   localparam logic IOPC_PLL_EN_RST = 1'b0;
   localparam logic IOPC_SYSDIV_RST = 1'b0;
   localparam logic [1:0] IOPC_CDIV_RST = 2'h0;

   // Pin configuration word
   typedef struct packed {
      logic stby_en;     // Pin zero drives transceiver standby
      logic pin1_irq;    // Pin one is rx interrupt
      logic pin0_irq;    // Pin zero is tx interrupt
      logic irq_od;      // Interrupt pins open drain
      logic tx_od;       // CAN tx open drain
      logic sof_sel;     // Shared pin shows start of frame
   } iopc_pin_cfg_s;

   // Oscillator control word
   typedef struct packed {
      logic [1:0] ref_sel;  // Reference kind
      logic pll_en;         // Multiply 4 MHz reference
      logic sys_div2;       // Halve system clock
      logic [1:0] cdiv;     // Clock output divider
   } iopc_osc_cfg_s;

   // Open-drain capable pin drive
   typedef struct packed {
      logic o;
      logic oe;
   } iopc_pin_drv_s;

   // Start of frame sequencer states
   typedef enum logic [2:0] {
      IOPC_SOF_IDLE = 3'b001,
      IOPC_SOF_WAIT = 3'b010,
      IOPC_SOF_HIGH = 3'b100
   } iopc_sof_e;
endpackage

// file: rtl/iopc_top.sv
/*
 Pin function, output stage and clock output logic of a CAN FD controller.
 Assumes configuration words arrive from logic on sys_clk; can_rx_pin and
 the auxiliary pin inputs come from pins and are synchronised here.
 The oscillator reference is modelled by the osc_tick pulse rate.

*/
`timescale 1ns/1ps
module iopc_top
(
   input wire logic sys_clk,                   // 200 MHz clock
   input wire logic rst,                       // Async reset, high
   input wire iopc_pkg::iopc_pin_cfg_s pin_config_reg,   // Pin function setup
   input wire iopc_pkg::iopc_osc_cfg_s osc_control_reg,  // Oscillator setup
   input wire logic osc_tick,                  // One pulse per reference period
   input wire logic [31:0] controller_irq_reg, // Interrupt flags
   input wire logic [31:0] irq_enable_reg,     // Interrupt enables
   input wire logic tx_irq_flag,               // Tx interrupt flag
   input wire logic tx_irq_enable,             // Tx interrupt enable
   input wire logic rx_irq_flag,               // Rx interrupt flag
   input wire logic rx_irq_enable,             // Rx interrupt enable
   input wire logic can_tx_level,              // Level from protocol engine
   input wire logic can_rx_pin,                // CAN rx pin
   input wire logic xcvr_standby_req,          // Protocol wants standby
   input wire logic [1:0] gpio_dir,            // 1 = input, per aux pin
   input wire logic [1:0] gpio_latch,          // GPIO output latch
   input wire logic aux_io_zero_i,             // Aux pin zero level
   input wire logic aux_io_one_i,              // Aux pin one level
   output logic [1:0] gpio_level,              // Synchronised aux levels
   output logic aux_io_zero_o,                 // Aux pin zero out
   output logic aux_io_zero_oe,                // Aux pin zero enable
   output logic aux_io_one_o,                  // Aux pin one out
   output logic aux_io_one_oe,                 // Aux pin one enable
   output logic irq_n_o,                       // Main interrupt out
   output logic irq_n_oe,                      // Main interrupt enable
   output logic can_tx_pin_o,                  // CAN tx out
   output logic can_tx_pin_oe,                 // CAN tx enable
   output logic clock_out_pin,                 // Clock or frame start
   output logic system_clock_tick,             // System clock rate pulse
   output logic [7:0] system_clock_mhz         // Effective system clock
);
   import iopc_pkg::*;

   logic [1:0] rx_sync_r, rx_sync_nxt;
   logic rx_prev_r, rx_prev_nxt;
   logic [1:0] aux0_sync_r, aux0_sync_nxt;
   logic [1:0] aux1_sync_r, aux1_sync_nxt;
   logic half_r, half_nxt;
   logic [3:0] cdiv_cnt_r, cdiv_cnt_nxt;
   logic clk_out_r, clk_out_nxt;
   logic [3:0] cdiv_half;
   logic sys_tick;
   iopc_sof_e sof_r, sof_nxt;
   logic [4:0] sof_cnt_r, sof_cnt_nxt;
   logic pin_out_r, pin_out_nxt;
   logic irq_main_r, irq_main_nxt;
   logic irq_tx_r, irq_tx_nxt;
   logic irq_rx_r, irq_rx_nxt;
   logic tx_lvl_r, tx_lvl_nxt;
   logic [1:0] aux_lvl_r, aux_lvl_nxt;
   logic [1:0] aux_act_r, aux_act_nxt;
   logic [1:0] aux_od;
   logic [7:0] mhz_r, mhz_nxt;
   iopc_pin_drv_s drv_tx, drv_main, drv_a0, drv_a1;

   // Effective system clock frequency from reference and oscillator setup
   always_comb
   begin
      case (osc_control_reg.ref_sel)
         IOPC_REF_40M: mhz_nxt = 8'(IOPC_REF_40_MHZ);
         IOPC_REF_20M: mhz_nxt = 8'(IOPC_REF_20_MHZ);
         IOPC_REF_4M:
         begin
            mhz_nxt = 8'(IOPC_REF_4_MHZ);
            if (osc_control_reg.pll_en)
            begin
               mhz_nxt = 8'(IOPC_REF_4_MHZ * IOPC_PLL_MULT);
            end
         end
         default: mhz_nxt = 8'(IOPC_REF_40_MHZ);
      endcase
      if (osc_control_reg.sys_div2)
      begin
         mhz_nxt = 8'(int'(mhz_nxt) / IOPC_SYS_DIV);
      end
   end

   // Halving stage: pass every other reference tick
   always_comb
   begin
      half_nxt = half_r;
      if (osc_tick)
      begin
         half_nxt = ~half_r;
      end
      sys_tick = osc_tick & (~osc_control_reg.sys_div2 | half_r);
   end

   // Output divider half period in system ticks, less one
   always_comb
   begin
      case (osc_control_reg.cdiv)
         IOPC_CDIV_1: cdiv_half = IOPC_CDIV_HALF_1;
         IOPC_CDIV_2: cdiv_half = IOPC_CDIV_HALF_2;
         IOPC_CDIV_4: cdiv_half = IOPC_CDIV_HALF_4;
         IOPC_CDIV_10: cdiv_half = IOPC_CDIV_HALF_10;
         default: cdiv_half = IOPC_CDIV_HALF_1;
      endcase
   end

   // Divider toggles the clock output; a tick rate of one gives half rate
   always_comb
   begin
      cdiv_cnt_nxt = cdiv_cnt_r;
      clk_out_nxt = clk_out_r;
      if (sys_tick)
      begin
         if (cdiv_cnt_r >= cdiv_half)
         begin
            cdiv_cnt_nxt = 4'h0;
            clk_out_nxt = ~clk_out_r;
         end
         else
         begin
            cdiv_cnt_nxt = cdiv_cnt_r + 4'h1;
         end
      end
   end

   // Pin input synchronisers; first stage feeds only the second
   always_comb
   begin
      rx_sync_nxt = {rx_sync_r[0], can_rx_pin};
      aux0_sync_nxt = {aux0_sync_r[0], aux_io_zero_i};
      aux1_sync_nxt = {aux1_sync_r[0], aux_io_one_i};
      rx_prev_nxt = rx_sync_r[1];
   end

   // Frame start sequencer counts system ticks, so timing follows the clock
   always_comb
   begin
      sof_nxt = sof_r;
      sof_cnt_nxt = sof_cnt_r;
      case (sof_r)
         IOPC_SOF_IDLE:
         begin
            if (rx_prev_r & ~rx_sync_r[1])
            begin
               sof_nxt = IOPC_SOF_WAIT;
               sof_cnt_nxt = 5'h00;
            end
         end
         IOPC_SOF_WAIT:
         begin
            if (sys_tick)
            begin
               if (sof_cnt_r + 5'h01 >= IOPC_SOF_DELAY_CNT)
               begin
                  sof_nxt = IOPC_SOF_HIGH;
                  sof_cnt_nxt = 5'h00;
               end
               else
               begin
                  sof_cnt_nxt = sof_cnt_r + 5'h01;
               end
            end
         end
         IOPC_SOF_HIGH:
         begin
            if (sys_tick)
            begin
               if (sof_cnt_r + 5'h01 >= IOPC_SOF_HIGH_CNT)
               begin
                  sof_nxt = IOPC_SOF_IDLE;
                  sof_cnt_nxt = 5'h00;
               end
               else
               begin
                  sof_cnt_nxt = sof_cnt_r + 5'h01;
               end
            end
         end
         default:
         begin
            sof_nxt = IOPC_SOF_IDLE;
            sof_cnt_nxt = 5'h00;
         end
      endcase
   end

   // Pin functions and interrupt levels, registered so outputs are clean
   always_comb
   begin
      pin_out_nxt = pin_config_reg.sof_sel ? (sof_r == IOPC_SOF_HIGH) : clk_out_r;
      irq_main_nxt = |(controller_irq_reg & irq_enable_reg);
      irq_tx_nxt = tx_irq_flag & tx_irq_enable;
      irq_rx_nxt = rx_irq_flag & rx_irq_enable;
      tx_lvl_nxt = can_tx_level;
      // Pin zero: standby, tx interrupt or GPIO
      if (pin_config_reg.stby_en)
      begin
         aux_lvl_nxt[0] = xcvr_standby_req;
         aux_act_nxt[0] = 1'b1;
      end
      else if (pin_config_reg.pin0_irq)
      begin
         aux_lvl_nxt[0] = ~irq_tx_nxt;
         aux_act_nxt[0] = 1'b1;
      end
      else
      begin
         aux_lvl_nxt[0] = gpio_latch[0];
         aux_act_nxt[0] = ~gpio_dir[0];
      end
      // Pin one: rx interrupt or GPIO
      if (pin_config_reg.pin1_irq)
      begin
         aux_lvl_nxt[1] = ~irq_rx_nxt;
         aux_act_nxt[1] = 1'b1;
      end
      else
      begin
         aux_lvl_nxt[1] = gpio_latch[1];
         aux_act_nxt[1] = ~gpio_dir[1];
      end
   end

   // Open drain applies to interrupt use; GPIO and standby stay push-pull
   assign aux_od[0] = pin_config_reg.irq_od & pin_config_reg.pin0_irq
      & ~pin_config_reg.stby_en;
   assign aux_od[1] = pin_config_reg.irq_od & pin_config_reg.pin1_irq;

   // State registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_sync_r <= 2'h3;
         rx_prev_r <= 1'b1;
         aux0_sync_r <= 2'h0;
         aux1_sync_r <= 2'h0;
         half_r <= 1'b0;
         cdiv_cnt_r <= 4'h0;
         clk_out_r <= 1'b0;
         sof_r <= IOPC_SOF_IDLE;
         sof_cnt_r <= 5'h00;
         pin_out_r <= 1'b0;
         irq_main_r <= 1'b0;
         irq_tx_r <= 1'b0;
         irq_rx_r <= 1'b0;
         tx_lvl_r <= 1'b1;
         aux_lvl_r <= 2'h3;
         aux_act_r <= 2'h0;
         mhz_r <= 8'h00;
      end
      else
      begin
         rx_sync_r <= rx_sync_nxt;
         rx_prev_r <= rx_prev_nxt;
         aux0_sync_r <= aux0_sync_nxt;
         aux1_sync_r <= aux1_sync_nxt;
         half_r <= half_nxt;
         cdiv_cnt_r <= cdiv_cnt_nxt;
         clk_out_r <= clk_out_nxt;
         sof_r <= sof_nxt;
         sof_cnt_r <= sof_cnt_nxt;
         pin_out_r <= pin_out_nxt;
         irq_main_r <= irq_main_nxt;
         irq_tx_r <= irq_tx_nxt;
         irq_rx_r <= irq_rx_nxt;
         tx_lvl_r <= tx_lvl_nxt;
         aux_lvl_r <= aux_lvl_nxt;
         aux_act_r <= aux_act_nxt;
         mhz_r <= mhz_nxt;
      end
   end

   // Output stages
   iopc_pin_drv u_drv_tx
   (
      .level(tx_lvl_r),
      .open_drain(pin_config_reg.tx_od),
      .active(1'b1),
      .drv(drv_tx)
   );

   iopc_pin_drv u_drv_main
   (
      .level(~irq_main_r),
      .open_drain(pin_config_reg.irq_od),
      .active(1'b1),
      .drv(drv_main)
   );

   iopc_pin_drv u_drv_a0
   (
      .level(aux_lvl_r[0]),
      .open_drain(aux_od[0]),
      .active(aux_act_r[0]),
      .drv(drv_a0)
   );

   iopc_pin_drv u_drv_a1
   (
      .level(aux_lvl_r[1]),
      .open_drain(aux_od[1]),
      .active(aux_act_r[1]),
      .drv(drv_a1)
   );

   assign can_tx_pin_o = drv_tx.o;
   assign can_tx_pin_oe = drv_tx.oe;
   assign irq_n_o = drv_main.o;
   assign irq_n_oe = drv_main.oe;
   assign aux_io_zero_o = drv_a0.o;
   assign aux_io_zero_oe = drv_a0.oe;
   assign aux_io_one_o = drv_a1.o;
   assign aux_io_one_oe = drv_a1.oe;
   // Pin level readable in either direction
   assign gpio_level = {aux1_sync_r[1], aux0_sync_r[1]};
   assign clock_out_pin = pin_out_r;
   assign system_clock_tick = sys_tick;
   assign system_clock_mhz = mhz_r;
endmodule // iopc_top

// file: testbench/iopc_monitor.sv
/*
 Assertions on the pin drive and shared pin of iopc_top.
 Assumes it is bound into iopc_top and sees one clock domain only.
*/
`timescale 1ns/1ps
module iopc_monitor (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire iopc_pkg::iopc_pin_cfg_s pin_config_reg, // Pin setup
   input wire logic [31:0] controller_irq_reg, // Flags
   input wire logic [31:0] irq_enable_reg, // Enables
   input wire logic tx_irq_flag, // Tx flag
   input wire logic tx_irq_enable, // Tx enable
   input wire logic rx_irq_flag, // Rx flag
   input wire logic rx_irq_enable, // Rx enable
   input wire logic can_tx_level, // Tx level
   input wire logic xcvr_standby_req, // Standby
   input wire logic aux_io_zero_i, // Aux zero in
   input wire logic aux_io_one_i, // Aux one in
   input wire logic [1:0] gpio_level, // Aux levels
   input wire logic aux_io_zero_o, // Aux zero out
   input wire logic aux_io_zero_oe, // Aux zero drive
   input wire logic aux_io_one_o, // Aux one out
   input wire logic aux_io_one_oe, // Aux one drive
   input wire logic irq_n_o, // Irq out
   input wire logic irq_n_oe, // Irq drive
   input wire logic can_tx_pin_o, // Tx out
   input wire logic can_tx_pin_oe, // Tx drive
   input wire logic clock_out_pin, // Shared pin
   input wire logic system_clock_tick // Tick
);
   import iopc_pkg::*;
   logic [5:0] hi_r;
   logic [5:0] hi_nxt;
   default clocking mon_cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Ticks seen while the shared pin is high
   always_comb
   begin
      hi_nxt = clock_out_pin ? hi_r + 6'(system_clock_tick) : 6'h00;
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         hi_r <= 6'h00;
      else
         hi_r <= hi_nxt;
   end
   // Mode bits must hold one cycle, as the drive follows live config
   sequence rx_req_s;
      pin_config_reg.pin1_irq && rx_irq_flag && rx_irq_enable ##1 $stable(pin_config_reg);
   endsequence
   sequence tx_req_s;
      pin_config_reg.pin0_irq && !pin_config_reg.stby_en && tx_irq_flag && tx_irq_enable
         ##1 $stable(pin_config_reg);
   endsequence
   main_irq_a:
      assert property (|(controller_irq_reg & irq_enable_reg) |=> irq_n_oe && !irq_n_o)
      else $error("main interrupt not asserted");
   irq_idle_a:
      assert property (!(|(controller_irq_reg & irq_enable_reg)) |=>
         (pin_config_reg.irq_od ? !irq_n_oe : irq_n_oe && irq_n_o))
      else $error("main interrupt idle drive wrong");
   tx_drive_a:
      assert property (1'b1 |=> (pin_config_reg.tx_od ?
         (can_tx_pin_oe == !$past(can_tx_level)) && !(can_tx_pin_oe && can_tx_pin_o) :
         can_tx_pin_oe && can_tx_pin_o == $past(can_tx_level)))
      else $error("can tx drive wrong");
   rx_aux_a:
      assert property (rx_req_s |-> aux_io_one_oe && !aux_io_one_o)
      else $error("rx interrupt pin not asserted");
   tx_aux_a:
      assert property (tx_req_s |-> aux_io_zero_oe && !aux_io_zero_o)
      else $error("tx interrupt pin not asserted");
   standby_out_a:
      assert property (pin_config_reg.stby_en ##1 $stable(pin_config_reg) |->
         aux_io_zero_oe && aux_io_zero_o == $past(xcvr_standby_req))
      else $error("standby pin wrong");
   gpio_sync_a:
      assert property (!$past(rst) && !$past(rst, 2) |->
         gpio_level == $past({aux_io_one_i, aux_io_zero_i}, 2))
      else $error("gpio level wrong");
   sof_width_a:
      assert property ($fell(clock_out_pin) && pin_config_reg.sof_sel &&
         $past(pin_config_reg.sof_sel, 32) |-> hi_r inside {[30:32]})
      else $error("frame start width wrong");
endmodule // iopc_monitor

bind iopc_top iopc_monitor u_iopc_monitor (.*);

// file: testbench/iopc_pin_partner.sv
/*
 Host interrupt inputs and transceiver lines seen as resolved wires.
 Assumes pull-ups on all four lines; only the aux lines have a far driver.
*/
`timescale 1ns/1ps
module iopc_pin_partner (
   input wire iopc_pkg::iopc_pin_drv_s [3:0] drv, // Irq, aux0, aux1, tx
   input wire logic [1:0] ext_en, // Far side drives aux
   input wire logic [1:0] ext_val, // Far side aux level
   output logic [3:0] wire_lvl, // Resolved lines
   output logic irq_pend // Host sees interrupt
);
   import iopc_pkg::*;
   // Released lines float to the pull-up, never to the last value
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         wire_lvl[i] = drv[i].oe ? drv[i].o : 1'b1;
      end
      // Far side drives an aux line only while the device lets it go
      if (!drv[1].oe && ext_en[0])
         wire_lvl[1] = ext_val[0];
      if (!drv[2].oe && ext_en[1])
         wire_lvl[2] = ext_val[1];
      irq_pend = !wire_lvl[0];
   end
endmodule // iopc_pin_partner

// file: testbench/tb.sv
/*
 Self-checking bench for iopc_top with the pin partner model.
 Assumes one 200 MHz clock; config and flags are plain ports.
*/
`timescale 1ns/1ps
module tb;
   import iopc_pkg::*;
   typedef struct packed {iopc_osc_cfg_s osc; logic [7:0] mhz; logic [7:0] per;} iopc_row_s;
   logic sys_clk = 1'b0, rst = 1'b1, osc_tick, tx_irq_flag, tx_irq_enable, rx_irq_flag;
   logic rx_irq_enable, can_tx_level, can_rx_pin, xcvr_standby_req, irq_n_o, irq_n_oe;
   logic aux_io_zero_i, aux_io_one_i, aux_io_zero_o, aux_io_zero_oe, aux_io_one_o;
   logic aux_io_one_oe, can_tx_pin_o, can_tx_pin_oe, clock_out_pin, system_clock_tick;
   logic irq_pend;
   logic [1:0] gpio_dir, gpio_latch, gpio_level, ext_en, ext_val;
   logic [3:0] wire_lvl;
   logic [7:0] system_clock_mhz, a, b;
   logic [31:0] controller_irq_reg, irq_enable_reg;
   iopc_pin_cfg_s pin_config_reg;
   iopc_osc_cfg_s osc_control_reg;
   iopc_pin_drv_s [3:0] drv;
   int n_errors = 0, samples_checked = 0, cycles = 0, i;
   // Reference, divider rows: osc word, MHz, clock out period in cycles
   iopc_row_s rows [8] = '{'{6'h00, 8'h28, 8'h02}, '{6'h11, 8'h14, 8'h04},
      '{6'h22, 8'h04, 8'h08}, '{6'h2B, 8'h28, 8'h14}, '{6'h04, 8'h14, 8'h04},
      '{6'h15, 8'h0A, 8'h08}, '{6'h2E, 8'h14, 8'h10}, '{6'h30, 8'h28, 8'h02}};
   iopc_top u_iopc_top (.*);
   iopc_pin_partner u_iopc_pin_partner (.*);
   assign drv = {can_tx_pin_o, can_tx_pin_oe, aux_io_one_o, aux_io_one_oe,
      aux_io_zero_o, aux_io_zero_oe, irq_n_o, irq_n_oe};
   assign aux_io_zero_i = wire_lvl[1];
   assign aux_io_one_i = wire_lvl[2];
   always #2.5 sys_clk = ~sys_clk;
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask
   // Bounded wait for a level on the shared pin, counting cycles
   task automatic wait_lvl(input logic v, output logic [7:0] n);
      n = 8'h00;
      while (clock_out_pin !== v && n < 8'hFF)
      begin
         step(1);
         n++;
      end
   endtask
   // The first partial phase is skipped after a divider change
   task automatic period(output logic [7:0] p);
      wait_lvl(1'b0, p);
      wait_lvl(1'b1, p);
      wait_lvl(1'b0, p);
      wait_lvl(1'b1, a);
      p = p + a;
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // A hang counts as a mismatch
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   initial
   begin
      {osc_tick, tx_irq_flag, tx_irq_enable, rx_irq_flag, rx_irq_enable} = 5'h10;
      {can_tx_level, can_rx_pin, xcvr_standby_req} = 3'h6;
      {gpio_dir, gpio_latch, ext_en, ext_val} = 8'hC0;
      {controller_irq_reg, irq_enable_reg} = 64'h0;
      pin_config_reg = IOPC_CFG_RST;
      osc_control_reg = 6'h00;
      step(11);
      check(8'({clock_out_pin, aux_io_zero_oe, aux_io_one_oe, gpio_level, wire_lvl[0],
         wire_lvl[3]}), 8'h03);
      check(system_clock_mhz, 8'h00);
      step(1);
      rst = 1'b0;
      foreach (rows[k])
      begin
         osc_control_reg = rows[k].osc;
         step(4);
         check(system_clock_mhz, rows[k].mhz);
         period(b);
         check(b, rows[k].per);
         // Halving passes one tick in two, so two samples sum to one
         a = 8'(system_clock_tick);
         step(1);
         a = a + 8'(system_clock_tick);
         check(a, rows[k].osc.sys_div2 ? 8'h01 : 8'h02);
      end
      // No reference tick, no system tick
      osc_tick = 1'b0;
      step(1);
      check(8'(system_clock_tick), 8'h00);
      osc_tick = 1'b1;
      // Both aux pins as interrupts, push-pull then open drain
      for (i = 0; i < 2; i++)
      begin
         pin_config_reg = {3'b011, i[0], 2'b00};
         {controller_irq_reg, irq_enable_reg} = {32'h8000_0001, 32'h0000_0001};
         {tx_irq_flag, tx_irq_enable, rx_irq_flag, rx_irq_enable} = 4'hE;
         step(2);
         check(8'({irq_pend, wire_lvl[2:1]}), 8'h06);
         controller_irq_reg = 32'h8000_0000;
         {tx_irq_flag, tx_irq_enable, rx_irq_flag, rx_irq_enable} = 4'hB;
         step(2);
         check(8'({irq_pend, wire_lvl[2:1], irq_n_oe, aux_io_zero_oe}),
            8'({3'b001, ~i[0], ~i[0]}));
      end
      pin_config_reg = IOPC_CFG_RST;
      {gpio_dir, gpio_latch} = 4'h2;
      step(4);
      check(8'({wire_lvl[2:1], gpio_level}), 8'h0A);
      {gpio_dir, gpio_latch, ext_en, ext_val} = 8'hCD;
      step(4);
      check(8'({wire_lvl[2:1], gpio_level, aux_io_zero_oe, aux_io_one_oe}), 8'h14);
      // Standby must win over a pending tx interrupt
      pin_config_reg = 6'h28;
      {tx_irq_flag, tx_irq_enable} = 2'h3;
      for (i = 0; i < 2; i++)
      begin
         xcvr_standby_req = i[0];
         step(2);
         check(8'({wire_lvl[1], aux_io_zero_oe}), 8'({i[0], 1'b1}));
      end
      for (i = 0; i < 4; i++)
      begin
         pin_config_reg.tx_od = i[1];
         can_tx_level = i[0];
         step(2);
         check(8'({wire_lvl[3], can_tx_pin_oe}), 8'({i[0], !(i[1] && i[0])}));
      end
      osc_control_reg = 6'h00;
      pin_config_reg = 6'h01;
      step(40);
      check(8'(clock_out_pin), 8'h00);
      can_rx_pin = 1'b0;
      wait_lvl(1'b1, a);
      check(8'(a inside {[8'h02:8'h06]}), 8'h01);
      wait_lvl(1'b0, b);
      check(b, 8'h1F);
      can_rx_pin = 1'b1;
      step(4);
      // Mid-run reset returns every pin to its idle drive
      rst = 1'b1;
      step(2);
      check(8'({clock_out_pin, aux_io_zero_oe, aux_io_one_oe, gpio_level, wire_lvl[0],
         wire_lvl[3]}), 8'h03);
      check(system_clock_mhz, 8'h00);
      rst = 1'b0;
      step(4);
      check(system_clock_mhz, 8'(IOPC_REF_40_MHZ));
      check(8'(clock_out_pin), 8'h00);
      give_verdict();
   end
endmodule // tb
